// [shared/ups_pkg.sv]
// constants and carriers for the serial-port strap capture block
// assumes a 250 MHz system clock and an 8-bit register port
package ups_pkg;

  // clock and strap window
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam int unsigned STRAP_WINDOW_NS = 100;
  localparam int unsigned STRAP_CYCLES    =
    (STRAP_WINDOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STRAP_CNT_W     = 8;

  // register offsets
  localparam logic [7:0] GLOBAL_OPTION_OFS   = 8'h24;
  localparam logic [7:0] CFG_PORT_OPTION_OFS = 8'h26;
  localparam logic [7:0] DEVICE_ACTIVATE_OFS = 8'h30;
  localparam logic [7:0] WATCHDOG_COUNT_OFS  = 8'hF6;
  localparam logic [7:0] MODEM_CTRL_A_OFS    = 8'h40;
  localparam logic [7:0] MODEM_CTRL_B_OFS    = 8'h41;
  localparam logic [7:0] HANDSHAKE_A_OFS     = 8'h42;
  localparam logic [7:0] HANDSHAKE_B_OFS     = 8'h43;

  // field positions
  localparam int unsigned DEFAULT_CLEAR_BIT  = 0;
  localparam int unsigned KBC_ENABLE_BIT     = 2;
  localparam int unsigned CLOCK48_BIT        = 6;
  localparam int unsigned CFG_PORT_SEL_BIT   = 6;
  localparam int unsigned WATCHDOG_EN_BIT    = 0;
  localparam int unsigned MC_REQUEST_BIT     = 0;
  localparam int unsigned MC_TERMINAL_BIT    = 1;
  localparam int unsigned HS_CLEAR_SEND_BIT  = 4;
  localparam int unsigned HS_SET_READY_BIT   = 5;
  localparam int unsigned HS_RING_BIT        = 6;
  localparam int unsigned HS_CARRIER_BIT     = 7;

  // values
  localparam logic [7:0] REG_RESET_VAL       = 8'h00;
  localparam logic [7:0] WATCHDOG_STRAP_CNT  = 8'h0A;
  localparam logic [7:0] CFG_ADDR_STRAP_HI   = 8'h4E;
  localparam logic [7:0] CFG_ADDR_STRAP_LO   = 8'h2E;

  // modem inputs of one port, all as seen on the pins
  typedef struct packed {
    logic clear_send_n;
    logic set_ready_n;
    logic carrier_detect_n;
    logic ring_ind_n;
    logic serial_in;
  } ups_modem_t;

  // strap levels captured at the end of the strap window
  typedef struct packed {
    logic cfg_port_select_strap;
    logic watchdog_enable_strap;
    logic default_clear_strap_n;
    logic keyboard_ctrl_enable_strap;
    logic clock48_strap;
  } ups_strap_t;

endpackage

// [src/ups_strap_capture.sv]
// strap capture and modem-control pins of two serial ports
// assumes: pins come from outside the clock domain, uart core and register
// port run on sys_clk_in, the pad turns *_oe_out low into an input
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - at power-on, port A request-send level loads config port select bit 6
// - config port select high makes 4EH the config port address
// - port B request-send level sets watchdog enable bit 0, count 0x0A
// - port A terminal-ready level sets global bit 0, clearing defaults
// - port A serial-out level sets global bit 2, keyboard ctrl enable
// - port B serial-out level sets global bit 6, the 48 setting
// - strap pins pulled down during power-on, floating pin reads zero
// - each port's clear-to-send input shows in handshake status bit 4
// - request-send and terminal-ready are driven low when ready
module ups_strap_capture
  import ups_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       clk_en_in,
  // register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // config port decode
  input  wire logic [7:0] io_addr_in,
  output logic      [7:0] cfg_port_addr_out,
  output logic            cfg_port_hit_out,
  // configuration bits toward the rest of the chip
  output logic            default_clear_out,
  output logic            keyboard_ctrl_enable_bit_out,
  output logic            clock48_bit_out,
  output logic            watchdog_enable_out,
  output logic      [7:0] watchdog_count_out,
  output logic            strap_phase_out,
  output logic            strap_pulldown_en_out,
  // uart core side
  input  wire logic       port_a_tx_data_in,
  input  wire logic       port_b_tx_data_in,
  output logic            port_a_serial_in_out,
  output logic            port_b_serial_in_out,
  // modem inputs
  input  wire ups_modem_t port_a_modem_in,
  input  wire ups_modem_t port_b_modem_in,
  // two-way pins
  input  wire logic       port_a_request_send_n_in,
  output logic            port_a_request_send_n_out,
  output logic            port_a_request_send_n_oe_out,
  input  wire logic       port_b_request_send_n_in,
  output logic            port_b_request_send_n_out,
  output logic            port_b_request_send_n_oe_out,
  input  wire logic       port_a_terminal_ready_n_in,
  output logic            port_a_terminal_ready_n_out,
  output logic            port_a_terminal_ready_n_oe_out,
  input  wire logic       port_b_terminal_ready_n_in,
  output logic            port_b_terminal_ready_n_out,
  output logic            port_b_terminal_ready_n_oe_out,
  input  wire logic       port_a_serial_out_in,
  output logic            port_a_serial_out_out,
  output logic            port_a_serial_out_oe_out,
  input  wire logic       port_b_serial_out_in,
  output logic            port_b_serial_out_out,
  output logic            port_b_serial_out_oe_out
);

  typedef enum logic [0:0] {
    ST_STRAP,
    ST_RUN
  } ups_state_t;

  localparam int unsigned SYNC_W = 15;

  // a change counts once the second and third stages agree
  function automatic logic [SYNC_W-1:0] filt_update(
    input logic [SYNC_W-1:0] s2,
    input logic [SYNC_W-1:0] s3,
    input logic [SYNC_W-1:0] held
  );
    filt_update = (s2 & s3) | (held & (s2 ^ s3));
  endfunction

  ups_state_t             state_ff;
  ups_state_t             nxt_state;
  logic [STRAP_CNT_W-1:0] strap_cnt_ff;
  logic [STRAP_CNT_W-1:0] nxt_strap_cnt;
  logic [SYNC_W-1:0]      sync1_ff;
  logic [SYNC_W-1:0]      sync2_ff;
  logic [SYNC_W-1:0]      sync3_ff;
  logic [SYNC_W-1:0]      filt_ff;
  logic [SYNC_W-1:0]      pin_raw;
  logic [7:0]             global_option_ff;
  logic [7:0]             nxt_global_option;
  logic [7:0]             cfg_port_option_ff;
  logic [7:0]             nxt_cfg_port_option;
  logic [7:0]             device_activate_ff;
  logic [7:0]             nxt_device_activate;
  logic [7:0]             watchdog_count_ff;
  logic [7:0]             nxt_watchdog_count;
  logic [7:0]             modem_ctrl_a_ff;
  logic [7:0]             nxt_modem_ctrl_a;
  logic [7:0]             modem_ctrl_b_ff;
  logic [7:0]             nxt_modem_ctrl_b;
  logic [7:0]             rdata_ff;
  logic [7:0]             nxt_rdata;
  logic                   tx_a_ff;
  logic                   tx_b_ff;
  ups_strap_t             strap_now;
  ups_modem_t             modem_a;
  ups_modem_t             modem_b;
  logic [7:0]             handshake_a;
  logic [7:0]             handshake_b;
  logic                   strap_done;
  logic                   capture;
  logic                   driving;
  logic                   wr_global;
  logic                   wr_cfg;
  logic                   wr_activate;
  logic                   wr_wdog;
  logic                   wr_mc_a;
  logic                   wr_mc_b;
  logic [7:0]             rd_mux;

  // every pin input except port B terminal-ready passes the same three stages
  assign pin_raw = {port_a_request_send_n_in,
                    port_b_request_send_n_in,
                    port_a_terminal_ready_n_in,
                    port_a_serial_out_in,
                    port_b_serial_out_in,
                    port_a_modem_in,
                    port_b_modem_in};

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      filt_ff  <= '0;
    end else if (clk_en_in) begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff  <= filt_update(sync2_ff, sync3_ff, filt_ff);
    end
  end

  // strap levels are taken from the filtered pins, never under reset
  assign strap_now = filt_ff[SYNC_W-1 -: 5];
  assign modem_a   = filt_ff[9:5];
  assign modem_b   = filt_ff[4:0];

  // strap window: pins float on their pull-downs, then one capture
  assign strap_done    = (strap_cnt_ff == STRAP_CNT_W'(STRAP_CYCLES - 1));
  assign capture       = (state_ff == ST_STRAP) && strap_done;
  assign driving       = (state_ff == ST_RUN);

  always_comb begin
    nxt_state     = state_ff;
    nxt_strap_cnt = strap_cnt_ff;
    case (state_ff)
      ST_STRAP: begin
        nxt_strap_cnt = strap_cnt_ff + STRAP_CNT_W'(1);
        if (strap_done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_strap_cnt = strap_cnt_ff;
      end
      default: begin
        nxt_state = ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff     <= ST_STRAP;
      strap_cnt_ff <= '0;
    end else if (clk_en_in) begin
      state_ff     <= nxt_state;
      strap_cnt_ff <= nxt_strap_cnt;
    end
  end

  // register write decode
  assign wr_global   = reg_wr_in && (reg_addr_in == GLOBAL_OPTION_OFS);
  assign wr_cfg      = reg_wr_in && (reg_addr_in == CFG_PORT_OPTION_OFS);
  assign wr_activate = reg_wr_in && (reg_addr_in == DEVICE_ACTIVATE_OFS);
  assign wr_wdog     = reg_wr_in && (reg_addr_in == WATCHDOG_COUNT_OFS);
  assign wr_mc_a     = reg_wr_in && (reg_addr_in == MODEM_CTRL_A_OFS);
  assign wr_mc_b     = reg_wr_in && (reg_addr_in == MODEM_CTRL_B_OFS);

  // capture loads only the strap bits and the whole watchdog count, and wins over a write that cycle
  always_comb begin
    nxt_global_option   = wr_global ? reg_wdata_in : global_option_ff;
    nxt_cfg_port_option = wr_cfg ? reg_wdata_in : cfg_port_option_ff;
    nxt_device_activate = wr_activate ? reg_wdata_in : device_activate_ff;
    nxt_watchdog_count  = wr_wdog ? reg_wdata_in : watchdog_count_ff;
    nxt_modem_ctrl_a    = wr_mc_a ? reg_wdata_in : modem_ctrl_a_ff;
    nxt_modem_ctrl_b    = wr_mc_b ? reg_wdata_in : modem_ctrl_b_ff;
    if (capture) begin
      nxt_cfg_port_option[CFG_PORT_SEL_BIT] =
        strap_now.cfg_port_select_strap;
      nxt_device_activate[WATCHDOG_EN_BIT] =
        strap_now.watchdog_enable_strap;
      nxt_watchdog_count = strap_now.watchdog_enable_strap ?
        WATCHDOG_STRAP_CNT : REG_RESET_VAL;
      nxt_global_option[DEFAULT_CLEAR_BIT] =
        strap_now.default_clear_strap_n;
      nxt_global_option[KBC_ENABLE_BIT] =
        strap_now.keyboard_ctrl_enable_strap;
      nxt_global_option[CLOCK48_BIT] =
        strap_now.clock48_strap;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      global_option_ff   <= REG_RESET_VAL;
      cfg_port_option_ff <= REG_RESET_VAL;
      device_activate_ff <= REG_RESET_VAL;
      watchdog_count_ff  <= REG_RESET_VAL;
      modem_ctrl_a_ff    <= REG_RESET_VAL;
      modem_ctrl_b_ff    <= REG_RESET_VAL;
    end else if (clk_en_in) begin
      global_option_ff   <= nxt_global_option;
      cfg_port_option_ff <= nxt_cfg_port_option;
      device_activate_ff <= nxt_device_activate;
      watchdog_count_ff  <= nxt_watchdog_count;
      modem_ctrl_a_ff    <= nxt_modem_ctrl_a;
      modem_ctrl_b_ff    <= nxt_modem_ctrl_b;
    end
  end

  // handshake status shows asserted modem lines as ones
  assign handshake_a = {~modem_a.carrier_detect_n,
                        ~modem_a.ring_ind_n,
                        ~modem_a.set_ready_n,
                        ~modem_a.clear_send_n,
                        4'h0};
  assign handshake_b = {~modem_b.carrier_detect_n,
                        ~modem_b.ring_ind_n,
                        ~modem_b.set_ready_n,
                        ~modem_b.clear_send_n,
                        4'h0};

  always_comb begin
    case (reg_addr_in)
      GLOBAL_OPTION_OFS:   rd_mux = global_option_ff;
      CFG_PORT_OPTION_OFS: rd_mux = cfg_port_option_ff;
      DEVICE_ACTIVATE_OFS: rd_mux = device_activate_ff;
      WATCHDOG_COUNT_OFS:  rd_mux = watchdog_count_ff;
      MODEM_CTRL_A_OFS:    rd_mux = modem_ctrl_a_ff;
      MODEM_CTRL_B_OFS:    rd_mux = modem_ctrl_b_ff;
      HANDSHAKE_A_OFS:     rd_mux = handshake_a;
      HANDSHAKE_B_OFS:     rd_mux = handshake_b;
      default:             rd_mux = REG_RESET_VAL;
    endcase
  end

  // read data stands only in the cycle after the strobe
  assign nxt_rdata = reg_rd_in ? rd_mux : REG_RESET_VAL;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= REG_RESET_VAL;
      tx_a_ff  <= 1'b1;
      tx_b_ff  <= 1'b1;
    end else if (clk_en_in) begin
      rdata_ff <= nxt_rdata;
      tx_a_ff  <= port_a_tx_data_in;
      tx_b_ff  <= port_b_tx_data_in;
    end
  end

  assign reg_rdata_out = rdata_ff;

  // config port address follows the captured select bit
  assign cfg_port_addr_out = cfg_port_option_ff[CFG_PORT_SEL_BIT] ?
    CFG_ADDR_STRAP_HI : CFG_ADDR_STRAP_LO;
  assign cfg_port_hit_out  = (io_addr_in == cfg_port_addr_out);

  assign default_clear_out            = global_option_ff[DEFAULT_CLEAR_BIT];
  assign keyboard_ctrl_enable_bit_out = global_option_ff[KBC_ENABLE_BIT];
  assign clock48_bit_out              = global_option_ff[CLOCK48_BIT];
  assign watchdog_enable_out          = device_activate_ff[WATCHDOG_EN_BIT];
  assign watchdog_count_out           = watchdog_count_ff;
  assign strap_phase_out              = (state_ff == ST_STRAP);
  // pull-downs only while straps are sampled, so they never load the driven line
  assign strap_pulldown_en_out        = (state_ff == ST_STRAP);

  // the set-ready, carrier and ring lines are active low from the modem
  assign port_a_serial_in_out = modem_a.serial_in;
  assign port_b_serial_in_out = modem_b.serial_in;

  // ready states are driven low; pins float during the strap window
  assign port_a_request_send_n_out   = ~modem_ctrl_a_ff[MC_REQUEST_BIT];
  assign port_b_request_send_n_out   = ~modem_ctrl_b_ff[MC_REQUEST_BIT];
  assign port_a_terminal_ready_n_out = ~modem_ctrl_a_ff[MC_TERMINAL_BIT];
  assign port_b_terminal_ready_n_out = ~modem_ctrl_b_ff[MC_TERMINAL_BIT];
  assign port_a_serial_out_out       = tx_a_ff;
  assign port_b_serial_out_out       = tx_b_ff;

  assign port_a_request_send_n_oe_out   = driving;
  assign port_b_request_send_n_oe_out   = driving;
  assign port_a_terminal_ready_n_oe_out = driving;
  assign port_b_terminal_ready_n_oe_out = driving;
  assign port_a_serial_out_oe_out       = driving;
  assign port_b_serial_out_oe_out       = driving;

  // port B terminal-ready carries no strap; its input is not needed
  logic unused_dtr_b;
  assign unused_dtr_b = port_b_terminal_ready_n_in;

endmodule // ups_strap_capture

`default_nettype wire

// [tb/ups_modem_model.sv]
// modem or data set on the far side of both serial ports
// assumes the bench picks the asserted lines; port b sees the complement
`timescale 1ns/1ps
`default_nettype none
module ups_modem_model
  import ups_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic [4:0] assert_a_in,
  output var ups_modem_t  port_a_modem_out,
  output var ups_modem_t  port_b_modem_out
);
  // bit 4 clear-send, 3 set-ready, 2 carrier, 1 ring, 0 serial level
  initial port_a_modem_out = 5'h1E;
  initial port_b_modem_out = 5'h1E;
  always @(posedge sys_clk_in) begin
    port_a_modem_out <= {~assert_a_in[4:1], assert_a_in[0]};
    port_b_modem_out <= {assert_a_in[4:1], ~assert_a_in[0]};
  end
endmodule // ups_modem_model
`default_nettype wire

// [tb/ups_strap_capture_chk.sv]
// checker for strap capture and strap pin release
// assumes bind onto ups_strap_capture with clk_en_in held high
`timescale 1ns/1ps
`default_nettype none
module ups_strap_capture_chk
  import ups_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] cfg_port_addr_out,
  input wire logic       default_clear_out,
  input wire logic       keyboard_ctrl_enable_bit_out,
  input wire logic       clock48_bit_out,
  input wire logic       watchdog_enable_out,
  input wire logic [7:0] watchdog_count_out,
  input wire logic       strap_phase_out,
  input wire logic       strap_pulldown_en_out,
  input wire logic       port_a_request_send_n_in,
  input wire logic       port_b_request_send_n_in,
  input wire logic       port_a_terminal_ready_n_in,
  input wire logic       port_a_serial_out_in,
  input wire logic       port_b_serial_out_in,
  input wire logic       port_a_request_send_n_oe_out,
  input wire logic       port_b_serial_out_oe_out,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_addr_in
);
  logic [7:0] strap_cnt_ff;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // counts window edges; a window stretched by clk_en would fail
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in) strap_cnt_ff <= 8'h00;
    else if (strap_phase_out) strap_cnt_ff <= strap_cnt_ff + 8'h01;
  sequence s_cap;
    $fell(strap_phase_out);
  endsequence
  property p_cfg_sel;
    s_cap |-> cfg_port_addr_out == ($past(port_a_request_send_n_in) ?
      CFG_ADDR_STRAP_HI : CFG_ADDR_STRAP_LO);
  endproperty
  a_cfg_sel: assert property (p_cfg_sel) else $error("port select");
  property p_wdog;
    s_cap |-> (watchdog_enable_out == $past(port_b_request_send_n_in)) &&
      (watchdog_count_out == (watchdog_enable_out ? WATCHDOG_STRAP_CNT : 8'h00));
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog strap");
  property p_dflt;
    s_cap |-> default_clear_out == $past(port_a_terminal_ready_n_in);
  endproperty
  a_dflt: assert property (p_dflt) else $error("default clear");
  property p_kbc;
    s_cap |-> keyboard_ctrl_enable_bit_out == $past(port_a_serial_out_in);
  endproperty
  a_kbc: assert property (p_kbc) else $error("kbc enable");
  property p_c48;
    s_cap |-> clock48_bit_out == $past(port_b_serial_out_in);
  endproperty
  a_c48: assert property (p_c48) else $error("clock48 bit");
  property p_pull;
    strap_phase_out |-> strap_pulldown_en_out &&
      !port_a_request_send_n_oe_out && !port_b_serial_out_oe_out;
  endproperty
  a_pull: assert property (p_pull) else $error("pins in window");
  property p_release;
    s_cap |-> strap_cnt_ff == 8'(STRAP_CYCLES) && !strap_pulldown_en_out &&
      port_a_request_send_n_oe_out && port_b_serial_out_oe_out;
  endproperty
  a_release: assert property (p_release) else $error("pin release");
  // once running, only a software write may move the strapped count
  property p_hold;
    !strap_phase_out && !(reg_wr_in && reg_addr_in == WATCHDOG_COUNT_OFS)
      |=> $stable(watchdog_count_out);
  endproperty
  a_hold: assert property (p_hold) else $error("strap hold");
  c_hi: cover property (s_cap ##0 cfg_port_addr_out == CFG_ADDR_STRAP_HI);
  c_lo: cover property (s_cap ##0 cfg_port_addr_out == CFG_ADDR_STRAP_LO);
  c_wdog: cover property (s_cap ##0 watchdog_enable_out);
endmodule // ups_strap_capture_chk
bind ups_strap_capture ups_strap_capture_chk ups_strap_capture_chk_i (
  .sys_clk_in, .rst_n_in, .cfg_port_addr_out, .default_clear_out,
  .keyboard_ctrl_enable_bit_out, .clock48_bit_out, .watchdog_enable_out,
  .watchdog_count_out, .strap_phase_out, .strap_pulldown_en_out,
  .port_a_request_send_n_in, .port_b_request_send_n_in,
  .port_a_terminal_ready_n_in, .port_a_serial_out_in, .port_b_serial_out_in,
  .port_a_request_send_n_oe_out, .port_b_serial_out_oe_out, .reg_wr_in,
  .reg_addr_in);
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench: strap capture, modem control and handshake status
// assumes the modem model on the far side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ups_pkg::*;
;
  logic       sys_clk_in, rst_n_in, reg_wr_in, reg_rd_in, tx_a, tx_b;
  logic [7:0] reg_addr_in, reg_wdata_in, io_addr_in, d, e;
  logic [5:0] strap_up, s;
  logic [4:0] assert_a;
  logic [31:0] rnd;
  int         mismatches, checks_done, k, j;
  ups_modem_t port_a_modem_in, port_b_modem_in;
  wire logic [7:0] reg_rdata_out, cfg_port_addr_out;
  wire logic       cfg_port_hit_out, strap_phase_out;
  // pin order: request a, request b, terminal a, terminal b, serial a, b
  wire logic [5:0] po, oe, pin;
  wire logic [1:0] sin;
  logic [7:0] ofs [4] = '{GLOBAL_OPTION_OFS, CFG_PORT_OPTION_OFS,
                          DEVICE_ACTIVATE_OFS, WATCHDOG_COUNT_OFS};
  // undriven pins sit on the external pull-up or the internal pull-down
  assign pin = (oe & po) | (~oe & strap_up);
  ups_strap_capture ups_strap_capture_i (.sys_clk_in, .rst_n_in,
    .clk_en_in(1'b1), .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .io_addr_in, .cfg_port_addr_out, .cfg_port_hit_out,
    .default_clear_out(), .keyboard_ctrl_enable_bit_out(), .clock48_bit_out(),
    .watchdog_enable_out(), .watchdog_count_out(), .strap_phase_out,
    .strap_pulldown_en_out(), .port_a_tx_data_in(tx_a),
    .port_b_tx_data_in(tx_b), .port_a_serial_in_out(sin[0]),
    .port_b_serial_in_out(sin[1]),
    .port_a_modem_in, .port_b_modem_in,
    .port_a_request_send_n_in(pin[0]), .port_a_request_send_n_out(po[0]),
    .port_a_request_send_n_oe_out(oe[0]), .port_b_request_send_n_in(pin[1]),
    .port_b_request_send_n_out(po[1]), .port_b_request_send_n_oe_out(oe[1]),
    .port_a_terminal_ready_n_in(pin[2]), .port_a_terminal_ready_n_out(po[2]),
    .port_a_terminal_ready_n_oe_out(oe[2]),
    .port_b_terminal_ready_n_in(pin[3]), .port_b_terminal_ready_n_out(po[3]),
    .port_b_terminal_ready_n_oe_out(oe[3]), .port_a_serial_out_in(pin[4]),
    .port_a_serial_out_out(po[4]), .port_a_serial_out_oe_out(oe[4]),
    .port_b_serial_out_in(pin[5]), .port_b_serial_out_out(po[5]),
    .port_b_serial_out_oe_out(oe[5]));
  ups_modem_model ups_modem_model_i (.sys_clk_in, .assert_a_in(assert_a),
    .port_a_modem_out(port_a_modem_in), .port_b_modem_out(port_b_modem_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] exp_reg(input logic [7:0] a, logic [5:0] t);
    case (a)
      GLOBAL_OPTION_OFS:   return {1'b0, t[5], 3'b000, t[4], 1'b0, t[2]};
      CFG_PORT_OPTION_OFS: return {1'b0, t[0], 6'h00};
      DEVICE_ACTIVATE_OFS: return {7'h00, t[1]};
      WATCHDOG_COUNT_OFS:  return t[1] ? WATCHDOG_STRAP_CNT : 8'h00;
      default:             return 8'h00;
    endcase
  endfunction
  // handshake view: carrier 7, ring 6, set-ready 5, clear-send 4
  function automatic logic [7:0] exp_hs(input logic [4:0] a);
    return {a[2], a[1], a[3], a[4], 4'h0};
  endfunction
  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [7:0] x, input logic [7:0] y);
    checks_done++;
    if (x !== y) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= v;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1; reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask
  initial begin
    rst_n_in = 1'b0; reg_wr_in = 1'b0; reg_rd_in = 1'b0; tx_a = 1'b1;
    tx_b = 1'b1; reg_addr_in = 8'h00; reg_wdata_in = 8'h00; io_addr_in = 8'h00;
    strap_up = 6'h00; assert_a = 5'h00; rnd = 32'h0000_1935;
    mismatches = 0; checks_done = 0;
    for (k = 0; k < 6; k++) begin
      s = (k == 0) ? 6'h00 : (k == 1) ? 6'h37 : rnd[5:0] & 6'h37;
      rnd = lfsr(rnd);
      @(posedge sys_clk_in);
      strap_up <= s; rst_n_in <= 1'b0;
      repeat (5) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      for (j = 0; j < 100 && strap_phase_out !== 1'b0; j++) @(posedge sys_clk_in);
      if (j == 100) begin
        mismatches++;
        finish_test();
      end
      strap_up <= ~s; // flipped pull levels must not reach the straps; all six pins are driven by now
      for (j = 0; j < 4; j++) begin
        rd(ofs[j], d);
        cmp("strap register", exp_reg(ofs[j], s), d);
      end
      e = s[0] ? CFG_ADDR_STRAP_HI : CFG_ADDR_STRAP_LO;
      cmp("config address", e, cfg_port_addr_out);
      @(posedge sys_clk_in);
      io_addr_in <= e ^ {7'h00, rnd[7]};
      #1 cmp("config hit", {7'h00, ~rnd[7]}, {7'h00, cfg_port_hit_out});
    end
    cmp("pin enables", 8'h3F, {2'b00, oe});
    for (j = 0; j < 4; j++) begin
      wr(MODEM_CTRL_A_OFS, j[7:0]);
      wr(MODEM_CTRL_B_OFS, j[7:0] ^ 8'h03);
      cmp("modem pins", {4'h0, j[1], ~j[1], j[0], ~j[0]}, {4'h0, pin[3:0]});
    end
    for (k = 0; k < 10; k++) begin
      @(posedge sys_clk_in);
      assert_a <= (k == 0) ? 5'h1F : (k == 1) ? 5'h00 : rnd[4:0];
      tx_a <= rnd[5]; tx_b <= rnd[6];
      rnd = lfsr(rnd);
      repeat (8) @(posedge sys_clk_in);
      wr(HANDSHAKE_A_OFS, 8'hFF);
      rd(HANDSHAKE_A_OFS, d);
      cmp("handshake a", exp_hs(assert_a), d);
      rd(HANDSHAKE_B_OFS, d);
      cmp("handshake b", exp_hs(~assert_a), d);
      cmp("serial pins", {6'h00, tx_b, tx_a}, {6'h00, pin[5], pin[4]});
      cmp("serial inputs", {6'h00, ~assert_a[0], assert_a[0]}, {6'h00, sin});
      rd(8'h55, d);
      cmp("unmapped read", 8'h00, d);
    end
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
